// File: hside_engine.sv
// isochronous descriptor engine: decodes one high-speed iso descriptor,
// issues packets per microframe and writes back count, halt, valid, status
// assumes a bus engine answering each packet request with one result pulse
//
// What this block does
// - stall sets halt and clears valid together
// - babble flag never reported for iso
// - write back fifteen bit bytes done
// - intermediate counts stored while packets pending
// - buffer pointer is cpu address less 400h over 8
// - frame taken from top five bits
// - split bit selects high speed or split
// - token 00 out, 01 in; kind iso
// - tokens go to seven bit address
// - endpoint number split across two words
// - multiplier limits packets per microframe
// - valid cleared after execution or fatal error
// - active microframes only, bit cleared after
// - microframe status error, babble, underrun bits
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "hside_consts.svh"
module hside_engine (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [63:0] dw0_in,
    input wire logic [63:0] dw1_in,
    input wire logic valid_set_in,
    input wire logic [4:0] bus_frame_in,
    input wire logic [2:0] bus_uframe_in,
    input wire logic sof_in,
    input wire logic pkt_ready_in,
    output logic pkt_valid_out,
    output hside_pkg::hside_pkt_t pkt_out,
    input wire logic res_valid_in,
    input wire hside_pkg::hside_res_t res_in,
    output logic [14:0] bytes_done_count_out,
    output logic halt_out,
    output logic babble_out,
    output logic valid_out,
    output logic [7:0] microframe_activation_mask_out,
    output logic [23:0] microframe_result_out,
    output logic desc_error_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out
);
    // register map: status(ro) 0, clear(wo) 1, enable 2, engine state 3
    localparam logic [3:0] REG_STAT = 4'h0;
    localparam logic [3:0] REG_CLR = 4'h1;
    localparam logic [3:0] REG_EN = 4'h2;
    localparam logic [3:0] REG_INFO = 4'h3;
    // irq bits: 0 done, 1 halt, 2 any microframe status bit (error, babble, underrun), 3 descriptor error
    hside_pkg::hside_desc_t d;
    hside_pkg::hside_st_t s_reg, s_next;
    logic desc_ok;
    logic frame_hit;
    logic [3:0] ev;

    // ram_ptr passes a ram word pointer through unchanged; cpu_to_ram maps a cpu byte address to a ram word pointer
    function automatic logic [15:0] ram_ptr(input logic [15:0] p);
        ram_ptr = p;
    endfunction
    function automatic logic [15:0] cpu_to_ram(input logic [18:0] a);
        logic [18:0] t;
        t = a - {3'h0, `HSIDE_RAM_BASE};
        cpu_to_ram = t[18:3];
    endfunction

    always_comb begin
        d.split_sel = dw1_in[46];
        d.endpoint_kind = dw1_in[45:44];
        d.token = dw1_in[43:42];
        d.dev_addr = dw1_in[41:35];
        d.endpoint_number = {dw1_in[34:32], dw0_in[31]};
        d.mult = dw0_in[30:29];
        d.packet_size_limit = dw0_in[28:18];
        d.bytes_requested_count = dw0_in[17:3];
        d.buffer_start_ptr = dw1_in[23:8];
        d.frame_num = dw1_in[7:3];
        d.microframe_activation_mask = s_reg.mask;
    end

    // rejects non-iso kinds, reserved tokens, zero mult and bad sizes
    assign desc_ok = d.endpoint_kind == `HSIDE_KIND_ISO
        && (d.token == `HSIDE_TOKEN_OUT || d.token == `HSIDE_TOKEN_IN)
        && d.mult != 2'h0
        && d.packet_size_limit <= `HSIDE_MAX_PKT
        && d.bytes_requested_count != 15'h0
        && d.bytes_requested_count <= `HSIDE_MAX_BYTES;
    assign frame_hit = bus_frame_in == d.frame_num;

    always_comb begin
        logic [10:0] len;
        logic [2:0] st;
        len = 11'h0;
        st = 3'h0;
        s_next = s_reg;
        ev = 4'h0;
        s_next.rdata = 32'h0;
        unique case (s_reg.state)
            hside_pkg::HS_IDLE: begin
                if (s_reg.valid && sof_in && frame_hit
                        && s_reg.mask[bus_uframe_in]) begin
                    if (!desc_ok) begin
                        s_next.valid = 1'b0;
                        ev[3] = 1'b1;
                    end else begin
                        s_next.uframe = bus_uframe_in;
                        s_next.pkts_left = d.mult;
                        s_next.ustat_acc = 3'h0;
                        s_next.state = hside_pkg::HS_ISSUE;
                    end
                end
            end
            hside_pkg::HS_ISSUE: begin
                if (pkt_ready_in) begin
                    s_next.state = hside_pkg::HS_WAIT;
                end
            end
            hside_pkg::HS_WAIT: begin
                if (res_valid_in) begin
                    len = res_in.bytes > d.packet_size_limit ?
                        d.packet_size_limit : res_in.bytes;
                    // intermediate count kept between packets
                    s_next.bytes_done = s_reg.bytes_done
                        + {4'h0, len};
                    s_next.bytes_left = s_reg.bytes_left > {4'h0, len} ?
                        s_reg.bytes_left - {4'h0, len} : 15'h0;
                    s_next.ptr = s_reg.ptr + {5'h0, len[10:3]}
                        + {15'h0, |len[2:0]};
                    s_next.pkts_left = s_reg.pkts_left - 2'h1;
                    st = {res_in.underrun
                        && d.token == `HSIDE_TOKEN_OUT,
                        res_in.babble && d.token == `HSIDE_TOKEN_IN,
                        res_in.xact_err};
                    s_next.ustat_acc = s_reg.ustat_acc | st;
                    if (res_in.stall) begin
                        s_next.halt = 1'b1;
                        s_next.valid = 1'b0;
                        ev[1] = 1'b1;
                        s_next.state = hside_pkg::HS_DONE;
                    end else if (s_reg.pkts_left == 2'h1 || st[0]
                            || len < d.packet_size_limit
                            || s_next.bytes_left == 15'h0) begin
                        s_next.state = hside_pkg::HS_DONE;
                    end else begin
                        s_next.state = hside_pkg::HS_ISSUE;
                    end
                end
            end
            hside_pkg::HS_DONE: begin
                s_next.mask[s_reg.uframe] = 1'b0;
                s_next.ustat[s_reg.uframe*3 +: 3] = s_reg.ustat_acc;
                ev[2] = |s_reg.ustat_acc;
                if (s_next.mask == 8'h0 || s_reg.bytes_left == 15'h0) begin
                    s_next.valid = 1'b0;
                    ev[0] = 1'b1;
                end
                s_next.state = hside_pkg::HS_IDLE;
            end
            default: s_next.state = hside_pkg::HS_IDLE;
        endcase
        // software arms the descriptor; fields reload from the words
        if (valid_set_in && s_reg.state == hside_pkg::HS_IDLE) begin
            s_next.valid = 1'b1;
            s_next.halt = 1'b0;
            s_next.bytes_done = 15'h0;
            s_next.bytes_left = d.bytes_requested_count;
            s_next.ptr = ram_ptr(d.buffer_start_ptr);
            s_next.mask = dw1_in[63:56] == 8'h0 ? 8'hff : dw1_in[63:56];
            s_next.ustat = 24'h0;
        end
        // set wins over a clear in the same cycle
        if (reg_wr_in && reg_addr_in == REG_CLR) begin
            s_next.irq_stat = s_reg.irq_stat & ~reg_wdata_in[3:0];
        end
        s_next.irq_stat = s_next.irq_stat | ev;
        if (reg_wr_in && reg_addr_in == REG_EN) begin
            s_next.irq_en = reg_wdata_in[3:0];
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_STAT: s_next.rdata = {28'h0, s_reg.irq_stat};
                REG_EN: s_next.rdata = {28'h0, s_reg.irq_en};
                REG_INFO: s_next.rdata = {s_reg.state, s_reg.halt,
                    s_reg.valid, s_reg.uframe, s_reg.mask,
                    s_reg.bytes_done};
                default: s_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '{state: hside_pkg::HS_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pkt_valid_out = s_reg.state == hside_pkg::HS_ISSUE;
    assign pkt_out = '{split_sel: d.split_sel, token: d.token,
        dev_addr: d.dev_addr, endpoint_number: d.endpoint_number,
        ram_addr: s_reg.ptr,
        length: s_reg.bytes_left < {4'h0, d.packet_size_limit} ?
            s_reg.bytes_left[10:0] : d.packet_size_limit};
    assign bytes_done_count_out = s_reg.bytes_done;
    assign halt_out = s_reg.halt;
    assign babble_out = 1'b0;
    assign valid_out = s_reg.valid;
    assign microframe_activation_mask_out = s_reg.mask;
    assign microframe_result_out = s_reg.ustat;
    assign desc_error_out = s_reg.irq_stat[3];
    assign reg_rdata_out = s_reg.rdata;
    assign irq_out = |(s_reg.irq_stat & s_reg.irq_en);

    property p_stall_halt;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state == hside_pkg::HS_WAIT && res_valid_in && res_in.stall
        |=> halt_out && !valid_out;
    endproperty
    a_stall_halt: assert property (p_stall_halt)
        else $error("stall did not halt and invalidate");
    property p_no_babble;
        @(posedge clk_in) disable iff (!rst_n_in) !babble_out;
    endproperty
    a_no_babble: assert property (p_no_babble)
        else $error("babble reported for iso");
    property p_count_adds;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state == hside_pkg::HS_WAIT && res_valid_in && !valid_set_in
        && res_in.bytes <= d.packet_size_limit
        |=> bytes_done_count_out == $past(bytes_done_count_out)
            + 15'($past(res_in.bytes));
    endproperty
    a_count_adds: assert property (p_count_adds)
        else $error("byte count not accumulated");
    property p_pkt_fields;
        @(posedge clk_in) disable iff (!rst_n_in)
        pkt_valid_out |-> pkt_out.dev_addr == dw1_in[41:35]
            && pkt_out.endpoint_number == {dw1_in[34:32], dw0_in[31]}
            && pkt_out.split_sel == dw1_in[46];
    endproperty
    a_pkt_fields: assert property (p_pkt_fields)
        else $error("packet address fields wrong");
    property p_pkt_len;
        @(posedge clk_in) disable iff (!rst_n_in)
        pkt_valid_out |-> pkt_out.length <= d.packet_size_limit;
    endproperty
    a_pkt_len: assert property (p_pkt_len)
        else $error("packet exceeds size limit");
    property p_wrong_frame;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state == hside_pkg::HS_IDLE && !frame_hit
        |=> s_reg.state == hside_pkg::HS_IDLE;
    endproperty
    a_wrong_frame: assert property (p_wrong_frame)
        else $error("issued in wrong frame");
    property p_mask_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state == hside_pkg::HS_DONE && !valid_set_in
        |=> !microframe_activation_mask_out[$past(s_reg.uframe)];
    endproperty
    a_mask_clear: assert property (p_mask_clear)
        else $error("activation bit not cleared");
    property p_mult_bound;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state != hside_pkg::HS_IDLE |-> s_reg.pkts_left <= d.mult;
    endproperty
    a_mult_bound: assert property (p_mult_bound)
        else $error("packets exceed multiplier");
    property p_done_valid;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_reg.state == hside_pkg::HS_DONE && s_next.mask == 8'h0
        && !valid_set_in |=> !valid_out ##1 !valid_out || valid_set_in;
    endproperty
    a_done_valid: assert property (p_done_valid)
        else $error("valid kept after execution");
endmodule // hside_engine

// File: hside_consts.svh
// constants for the isochronous descriptor engine: ram mapping, codes, limits
// assumes inclusion by the engine module and by the testbench
`ifndef HSIDE_CONSTS_SVH
`define HSIDE_CONSTS_SVH
`define HSIDE_RAM_BASE 16'h0400
`define HSIDE_RAM_SHIFT 3
`define HSIDE_TOKEN_OUT 2'h0
`define HSIDE_TOKEN_IN 2'h1
`define HSIDE_KIND_ISO 2'h1
`define HSIDE_MAX_PKT 11'h400
`define HSIDE_MAX_BYTES 15'h5000
`define HSIDE_UFRAMES 8
`endif

// File: hside_pkg.sv
// types for the isochronous descriptor engine
// widths and state codes written out here; hside_consts.svh is not used
package hside_pkg;
    // decoded descriptor words as software leaves them
    typedef struct packed {
        logic split_sel;
        logic [1:0] endpoint_kind;
        logic [1:0] token;
        logic [6:0] dev_addr;
        logic [3:0] endpoint_number;
        logic [1:0] mult;
        logic [10:0] packet_size_limit;
        logic [14:0] bytes_requested_count;
        logic [15:0] buffer_start_ptr;
        logic [4:0] frame_num;
        logic [7:0] microframe_activation_mask;
    } hside_desc_t;
    // one packet request to the bus engine
    typedef struct packed {
        logic split_sel;
        logic [1:0] token;
        logic [6:0] dev_addr;
        logic [3:0] endpoint_number;
        logic [15:0] ram_addr;
        logic [10:0] length;
    } hside_pkt_t;
    // answer of the bus engine for one packet
    typedef struct packed {
        logic stall;
        logic xact_err;
        logic babble;
        logic underrun;
        logic [10:0] bytes;
    } hside_res_t;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_ISSUE = 4'h2,
        HS_WAIT = 4'h4,
        HS_DONE = 4'h8
    } hside_state_t;
    typedef struct packed {
        hside_state_t state;
        logic [2:0] uframe;
        logic [1:0] pkts_left;
        logic [14:0] bytes_done;
        logic [14:0] bytes_left;
        logic [15:0] ptr;
        logic [2:0] ustat_acc;
        logic halt;
        logic valid;
        logic [7:0] mask;
        logic [23:0] ustat;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [31:0] rdata;
    } hside_st_t;
endpackage

// File: hside_ep_model.sv
// behavioural iso endpoint standing behind the packet port of the engine
// assumes the engine holds pkt_valid_out until it sees pkt_ready_in
`timescale 1ns/1ns
module hside_ep_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pkt_valid_in,
    input wire hside_pkg::hside_pkt_t pkt_in,
    input wire logic slow_in,
    input wire logic stall_in,
    input wire logic babble_in,
    output logic pkt_ready_out,
    output logic res_valid_out,
    output hside_pkg::hside_res_t res_out
);
    hside_pkg::hside_res_t r;
    initial begin
        pkt_ready_out = 1'b0;
        res_valid_out = 1'b0;
        res_out = '0;
    end
    always begin
        @(posedge clk_in);
        if (rst_n_in && pkt_valid_in) begin
            if (slow_in) repeat (3) @(posedge clk_in);
            pkt_ready_out <= 1'b1;
            @(posedge clk_in);
            pkt_ready_out <= 1'b0;
            repeat (slow_in ? 4 : 1) @(posedge clk_in);
            // a whole packet always comes back, never more than asked
            r = '{stall: stall_in, xact_err: 1'b0, babble: babble_in,
                underrun: 1'b0, bytes: pkt_in.length};
            res_valid_out <= 1'b1;
            res_out <= r;
            @(posedge clk_in);
            res_valid_out <= 1'b0;
            // released answer lines show junk, not the last result
            res_out <= ~r;
        end
    end
endmodule // hside_ep_model

// File: hside_engine_tb.sv
// scenario testbench for the iso descriptor engine with an endpoint model
// assumes hside_pkg, hside_engine and hside_ep_model are compiled first
`timescale 1ns/1ns
`include "hside_consts.svh"
module hside_engine_tb;
    logic clk_in, rst_n_in, valid_set_in, sof_in, reg_wr_in, reg_rd_in;
    logic [63:0] dw0_in, dw1_in;
    logic [4:0] bus_frame_in;
    logic [2:0] bus_uframe_in;
    logic [3:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd;
    logic pkt_ready_in, pkt_valid_out, res_valid_in, halt_out, babble_out;
    logic valid_out, desc_error_out, irq_out, slow, stall, babble;
    hside_pkg::hside_pkt_t pkt_out;
    hside_pkg::hside_res_t res_in;
    logic [14:0] bytes_done_count_out;
    logic [7:0] microframe_activation_mask_out;
    logic [23:0] microframe_result_out;
    hside_pkg::hside_pkt_t q[$];
    int fail_count = 0;
    int total_checks = 0;
    hside_engine hside_engine_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .dw0_in(dw0_in), .dw1_in(dw1_in), .valid_set_in(valid_set_in),
        .bus_frame_in(bus_frame_in), .bus_uframe_in(bus_uframe_in),
        .sof_in(sof_in), .pkt_ready_in(pkt_ready_in),
        .pkt_valid_out(pkt_valid_out), .pkt_out(pkt_out),
        .res_valid_in(res_valid_in), .res_in(res_in),
        .bytes_done_count_out(bytes_done_count_out), .halt_out(halt_out),
        .babble_out(babble_out), .valid_out(valid_out),
        .microframe_activation_mask_out(microframe_activation_mask_out),
        .microframe_result_out(microframe_result_out),
        .desc_error_out(desc_error_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .irq_out(irq_out));
    hside_ep_model hside_ep_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pkt_valid_in(pkt_valid_out), .pkt_in(pkt_out), .slow_in(slow),
        .stall_in(stall), .babble_in(babble), .pkt_ready_out(pkt_ready_in),
        .res_valid_out(res_valid_in), .res_out(res_in));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (pkt_valid_out && pkt_ready_in) q.push_back(pkt_out);
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask
    // loads both words with reserved ranges zero except dw1 bits 2:0, which take the low three bits of fr, and arms the descriptor
    task automatic arm(input logic sp, input logic [1:0] tk,
        input logic [6:0] ad,
        input logic [3:0] ep, input logic [1:0] mu, input logic [14:0] by,
        input logic [15:0] cpu, input logic [7:0] fr, input logic [7:0] mk);
        @(posedge clk_in);
        dw0_in <= {32'h0, ep[0], mu, `HSIDE_MAX_PKT, by, 3'h0};
        dw1_in <= {mk, 9'h0, sp, `HSIDE_KIND_ISO, tk, ad, ep[3:1], 8'h0,
            (cpu - `HSIDE_RAM_BASE) >> `HSIDE_RAM_SHIFT, fr};
        valid_set_in <= 1'b1;
        @(posedge clk_in);
        valid_set_in <= 1'b0;
        #1 chk(valid_out, 1, "armed");
    endtask
    task automatic sof(input logic [4:0] f, input logic [2:0] u);
        @(posedge clk_in);
        bus_frame_in <= f;
        bus_uframe_in <= u;
        sof_in <= 1'b1;
        @(posedge clk_in);
        sof_in <= 1'b0;
        for (int i = 0; i < 80 && valid_out === 1'b1; i++) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic t_in_basic();
        q.delete();
        arm(1, `HSIDE_TOKEN_IN, 7'h5a, 4'hb, 2'h1, 15'h0400, 16'h1400,
            8'h9d, 8'h01);
        sof(5'h13, 3'h1);
        sof(5'h12, 3'h0);
        chk(q.size(), 0, "packet outside slot");
        sof(5'h13, 3'h0);
        chk(q.size(), 1, "packet count");
        chk(q[0].split_sel, 1, "split");
        chk(q[0].token, `HSIDE_TOKEN_IN, "token");
        chk(q[0].dev_addr, 7'h5a, "address");
        chk(q[0].endpoint_number, 4'hb, "endpoint");
        chk(q[0].ram_addr, 16'h0200, "ram address");
        chk(q[0].length, 11'h400, "length");
        chk(bytes_done_count_out, 15'h0400, "bytes done");
        chk(valid_out, 0, "valid after run");
        chk(microframe_activation_mask_out, 8'h00, "mask bit");
    endtask
    task automatic t_out_mult2();
        q.delete();
        slow = 1'b1;
        arm(0, `HSIDE_TOKEN_OUT, 7'h01, 4'h0, 2'h2, 15'h0800, 16'h0400,
            8'h00, 8'h04);
        sof(5'h00, 3'h2);
        chk(q.size(), 2, "two packets");
        chk(q[0].split_sel, 0, "high speed");
        chk(q[0].token, `HSIDE_TOKEN_OUT, "out token");
        chk(q[1].ram_addr, 16'h0080, "second address");
        chk(bytes_done_count_out, 15'h0800, "total bytes");
        chk(microframe_result_out[8:6], 3'h0, "clean status");
        slow = 1'b0;
    endtask
    task automatic t_stall();
        q.delete();
        stall = 1'b1;
        arm(0, `HSIDE_TOKEN_IN, 7'h22, 4'h3, 2'h3, 15'h1000, 16'h0800,
            8'h38, 8'h80);
        sof(5'h07, 3'h7);
        chk(halt_out, 1, "halt");
        chk(valid_out, 0, "valid with halt");
        chk(q.size(), 1, "no packet after stall");
        stall = 1'b0;
    endtask
    task automatic t_irq();
        reg_wr(4'h2, 32'h0);
        reg_wr(4'h1, 32'hf);
        reg_rd(4'h0);
        chk(rd, 0, "status cleared");
        arm(0, `HSIDE_TOKEN_OUT, 7'h03, 4'h1, 2'h1, 15'h0010, 16'h0400,
            8'h00, 8'h01);
        sof(5'h00, 3'h0);
        reg_rd(4'h0);
        chk(rd[0], 1, "done status");
        chk(irq_out, 0, "masked");
        reg_wr(4'h2, 32'h1);
        #1 chk(irq_out, 1, "irq raised");
        reg_wr(4'h1, 32'h1);
        #1 chk(irq_out, 0, "irq cleared");
        reg_rd(4'hf);
        chk(rd, 0, "unmapped read");
    endtask
    task automatic t_babble();
        babble = 1'b1;
        arm(0, `HSIDE_TOKEN_IN, 7'h44, 4'h2, 2'h1, 15'h0100, 16'h0400,
            8'h00, 8'h01);
        sof(5'h00, 3'h0);
        chk(babble_out, 0, "babble flag");
        chk(microframe_result_out[2:0], 3'h2, "babble status");
        babble = 1'b0;
    endtask
    // a reserved token must be refused and flagged, never issued
    task automatic t_bad_desc();
        q.delete();
        arm(0, 2'h2, 7'h11, 4'h1, 2'h1, 15'h0010, 16'h0400, 8'h00, 8'h01);
        sof(5'h00, 3'h0);
        chk(q.size(), 0, "bad token issued");
        chk(valid_out, 0, "bad descriptor valid");
        chk(desc_error_out, 1, "descriptor error");
        reg_wr(4'h1, 32'h8);
        #1 chk(desc_error_out, 0, "descriptor error cleared");
    endtask
    // mid-run reset must drop the halt left by the stall scenario and keep valid low
    task automatic t_reset();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk(halt_out, 0, "halt after reset");
        chk(valid_out, 0, "valid after reset");
    endtask
    initial begin
        rst_n_in = 1'b0;
        {valid_set_in, sof_in, reg_wr_in, reg_rd_in, slow, stall, babble} = '0;
        dw0_in = '0;
        dw1_in = '0;
        bus_frame_in = '0;
        bus_uframe_in = '0;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_in_basic();
        t_out_mult2();
        t_stall();
        t_reset();
        t_irq();
        t_babble();
        t_bad_desc();
        results();
    end
    // whole run needs well under 2000 cycles
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule // hside_engine_tb
